// [common/phy_mgmt_pkg.sv]
package phy_mgmt_pkg;

    // ----------------------------------------
    // Register numbers and the hardwired PHY address on the management frame
    // ----------------------------------------
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_AUTONEG_ADVERTISEMENT = 5'h04;
    localparam logic [4:0] REG_LINK_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0] REG_AUTONEG_EXPANSION = 5'h06;
    localparam logic [4:0] HARDWIRED_PHY_ADDRESS = 5'h00;

    // ----------------------------------------
    // Frame fields
    // ----------------------------------------
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam int PREAMBLE_BITS = 32;
    localparam logic [5:0] LAST_OP_BIT = 6'h01;
    localparam logic [5:0] LAST_ADDR_BIT = 6'h04;
    localparam logic [5:0] LAST_DATA_BIT = 6'h0f;

    // ----------------------------------------
    // Basic status bit positions
    // ----------------------------------------
    localparam int STAT_FOUR_PAIR = 15;
    localparam int STAT_TX_FULL = 14;
    localparam int STAT_TX_HALF = 13;
    localparam int STAT_TEN_FULL = 12;
    localparam int STAT_TEN_HALF = 11;
    localparam int STAT_AN_COMPLETE = 5;
    localparam int STAT_AN_ABILITY = 3;
    localparam int STAT_LINK = 2;
    localparam int STAT_EXTENDED = 0;

    // ----------------------------------------
    // Advertisement layout and reset value
    // ----------------------------------------
    localparam int ADV_NEXT_PAGE = 15;
    localparam int ADV_FOUR_PAIR = 9;
    localparam int ADV_TEN_FULL = 6;
    localparam int ADV_TEN_HALF = 5;
    localparam logic [15:0] ADV_WRITE_MASK = 16'h23e0;
    localparam logic [15:0] ADV_RESET = 16'h0181;

    // ----------------------------------------
    // Expansion bit positions
    // ----------------------------------------
    localparam int EXP_MULTI_FAULT = 4;
    localparam int EXP_LP_NEXT_PAGE = 3;
    localparam int EXP_NEXT_PAGE = 2;
    localparam int EXP_PAGE_RCVD = 1;
    localparam int EXP_LP_AN_ABLE = 0;

endpackage

// [core/mgmt_pin_sync.sv]
`timescale 1ns/1ps

module mgmt_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } sync_t;

    sync_t st;
    sync_t next_st;

    initial begin
        if (WIDTH < 1) begin
            $error("mgmt_pin_sync: WIDTH must be at least 1");
        end
    end

    // ----------------------------------------
    // Three stages; a change counts once the last two agree
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = i_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.level[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    assign o_level = st.level;

endmodule

// [core/phy_mgmt_status_autoneg_regs.sv]
`timescale 1ns/1ps


module phy_mgmt_status_autoneg_regs #(
    parameter int PREAMBLE_LEN = phy_mgmt_pkg::PREAMBLE_BITS
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire logic i_init_load,
    input wire logic i_init_hardwired,
    input wire logic [4:0] i_init_phy_address,
    input wire logic i_init_four_pair_capability,
    input wire logic i_init_ten_full_duplex,
    input wire logic i_init_ten_half_duplex,
    input wire logic i_link_up,
    input wire logic i_autoneg_complete,
    input wire logic i_lp_word_valid,
    input wire logic [15:0] i_lp_word,
    input wire logic i_page_received,
    input wire logic i_multi_link_good,
    input wire logic i_lp_next_page_able,
    input wire logic i_lp_autoneg_able,
    output logic [15:0] o_advertisement
);

    // ----------------------------------------
    // Types and state
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_PREAMBLE,
        ST_START,
        ST_OP,
        ST_PHY_ADDR,
        ST_REGAD,
        ST_TA,
        ST_DATA
    } frame_state_t;

    typedef struct packed {
        frame_state_t state;
        logic [5:0] cnt;
        logic [15:0] shreg;
        logic is_read;
        logic match;
        logic [4:0] regad;
        logic mdio_out;
        logic mdio_oe;
        logic mdc_prev;
        logic cap_four_pair;
        logic cap_ten_full;
        logic cap_ten_half;
        logic [4:0] phy_address;
        logic [15:0] adv;
        logic [15:0] lp;
        logic link_latched;
        logic an_complete;
        logic multi_fault;
        logic page_rcvd;
        logic lp_np_able;
        logic lp_an_able;
    } core_t;

    localparam logic [5:0] PRE_LEN = 6'(PREAMBLE_LEN);

    core_t st;
    core_t next_st;
    logic mdc_level;
    logic mdio_level;

    initial begin
        if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 63) begin
            $error("PREAMBLE_LEN must lie between 1 and 63");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    mgmt_pin_sync #(
        .WIDTH(2)
    ) mgmt_pin_sync_i (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_pin({i_mdc, i_mdio}),
        .o_level({mdc_level, mdio_level})
    );

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    function automatic logic [15:0] status_word(input core_t s);
        logic [15:0] w;
        w = '0;
        w[phy_mgmt_pkg::STAT_FOUR_PAIR] = s.cap_four_pair;
        w[phy_mgmt_pkg::STAT_TEN_FULL] = s.cap_ten_full;
        w[phy_mgmt_pkg::STAT_TEN_HALF] = s.cap_ten_half;
        w[phy_mgmt_pkg::STAT_TX_FULL] = 1'b1;
        w[phy_mgmt_pkg::STAT_TX_HALF] = 1'b1;
        w[phy_mgmt_pkg::STAT_AN_COMPLETE] = s.an_complete;
        w[phy_mgmt_pkg::STAT_AN_ABILITY] = 1'b1;
        w[phy_mgmt_pkg::STAT_LINK] = s.link_latched;
        w[phy_mgmt_pkg::STAT_EXTENDED] = 1'b1;
        return w;
    endfunction

    function automatic logic [15:0] expansion_word(input core_t s);
        logic [15:0] w;
        w = '0;
        w[phy_mgmt_pkg::EXP_MULTI_FAULT] = s.multi_fault;
        w[phy_mgmt_pkg::EXP_LP_NEXT_PAGE] = s.lp_np_able;
        w[phy_mgmt_pkg::EXP_NEXT_PAGE] = 1'b0;
        w[phy_mgmt_pkg::EXP_PAGE_RCVD] = s.page_rcvd;
        w[phy_mgmt_pkg::EXP_LP_AN_ABLE] = s.lp_an_able;
        return w;
    endfunction

    function automatic logic [15:0] reg_read(input core_t s,
                                             input logic [4:0] ra);
        logic [15:0] w;
        w = '0;
        unique case (ra)
            phy_mgmt_pkg::REG_BASIC_STATUS: begin
                w = status_word(s);
            end
            phy_mgmt_pkg::REG_AUTONEG_ADVERTISEMENT: begin
                w = s.adv;
            end
            phy_mgmt_pkg::REG_LINK_PARTNER_ABILITY: begin
                w = s.lp;
            end
            phy_mgmt_pkg::REG_AUTONEG_EXPANSION: begin
                w = expansion_word(s);
            end
            default: begin
                w = '0;
            end
        endcase
        return w;
    endfunction

    function automatic logic addr_ok(input core_t s,
                                     input logic hardwired,
                                     input logic [4:0] pa);
        logic ok;
        ok = hardwired ? (pa == phy_mgmt_pkg::HARDWIRED_PHY_ADDRESS)
                       : (pa == s.phy_address);
        return ok;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic rise;
        logic bit_in;
        logic rd_stat;
        logic rd_exp;
        logic wr_adv;
        logic [15:0] wdata;
        logic [4:0] field;
        rise = 1'b0;
        bit_in = 1'b0;
        rd_stat = 1'b0;
        rd_exp = 1'b0;
        wr_adv = 1'b0;
        wdata = '0;
        field = '0;
        next_st = st;
        next_st.mdc_prev = mdc_level;
        rise = mdc_level & ~st.mdc_prev;
        bit_in = mdio_level;
        field = {st.shreg[3:0], bit_in};
        wdata = {st.shreg[14:0], bit_in};

        // Frame walker; MDC is slow against the system clock
        if (rise) begin
            unique case (st.state)
                ST_PREAMBLE: begin
                    if (bit_in) begin
                        if (st.cnt < PRE_LEN) begin
                            next_st.cnt = st.cnt + 6'h01;
                        end
                    end else if (st.cnt >= PRE_LEN) begin
                        next_st.state = ST_START;
                        next_st.cnt = '0;
                    end else begin
                        next_st.cnt = '0;
                    end
                end
                ST_START: begin
                    next_st.cnt = '0;
                    next_st.state = bit_in ? ST_OP : ST_PREAMBLE;
                end
                ST_OP: begin
                    next_st.shreg = wdata;
                    next_st.cnt = st.cnt + 6'h01;
                    if (st.cnt == phy_mgmt_pkg::LAST_OP_BIT) begin
                        next_st.cnt = '0;
                        if (field[1:0] == phy_mgmt_pkg::OP_READ) begin
                            next_st.is_read = 1'b1;
                            next_st.state = ST_PHY_ADDR;
                        end else if (field[1:0] == phy_mgmt_pkg::OP_WRITE) begin
                            next_st.is_read = 1'b0;
                            next_st.state = ST_PHY_ADDR;
                        end else begin
                            next_st.state = ST_PREAMBLE;
                        end
                    end
                end
                ST_PHY_ADDR: begin
                    next_st.shreg = wdata;
                    next_st.cnt = st.cnt + 6'h01;
                    if (st.cnt == phy_mgmt_pkg::LAST_ADDR_BIT) begin
                        next_st.cnt = '0;
                        next_st.match = addr_ok(st, i_init_hardwired, field);
                        next_st.state = ST_REGAD;
                    end
                end
                ST_REGAD: begin
                    next_st.shreg = wdata;
                    next_st.cnt = st.cnt + 6'h01;
                    if (st.cnt == phy_mgmt_pkg::LAST_ADDR_BIT) begin
                        next_st.cnt = '0;
                        next_st.regad = field;
                        next_st.state = ST_TA;
                        if (st.is_read && st.match) begin
                            // Snapshot taken here; clear-on-read acts now
                            next_st.shreg = reg_read(st, field);
                            rd_stat =
                                field == phy_mgmt_pkg::REG_BASIC_STATUS;
                            rd_exp =
                                field == phy_mgmt_pkg::REG_AUTONEG_EXPANSION;
                        end
                    end
                end
                ST_TA: begin
                    next_st.cnt = st.cnt + 6'h01;
                    if (st.cnt == '0) begin
                        if (st.is_read && st.match) begin
                            next_st.mdio_oe = 1'b1;
                            next_st.mdio_out = 1'b0;
                        end
                    end else begin
                        next_st.cnt = '0;
                        next_st.state = ST_DATA;
                        if (st.is_read && st.match) begin
                            next_st.mdio_out = st.shreg[15];
                            next_st.shreg = {st.shreg[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    next_st.cnt = st.cnt + 6'h01;
                    if (st.is_read) begin
                        next_st.mdio_out = st.shreg[15];
                        next_st.shreg = {st.shreg[14:0], 1'b0};
                    end else begin
                        next_st.shreg = wdata;
                    end
                    if (st.cnt == phy_mgmt_pkg::LAST_DATA_BIT) begin
                        next_st.cnt = '0;
                        next_st.state = ST_PREAMBLE;
                        next_st.mdio_oe = 1'b0;
                        next_st.mdio_out = 1'b0;
                        wr_adv = ~st.is_read & st.match & (st.regad ==
                            phy_mgmt_pkg::REG_AUTONEG_ADVERTISEMENT);
                    end
                end
            endcase
        end

        // Advertisement: only the writable bits follow the host
        if (wr_adv) begin
            next_st.adv = (st.adv & ~phy_mgmt_pkg::ADV_WRITE_MASK) |
                          (wdata & phy_mgmt_pkg::ADV_WRITE_MASK);
        end
        next_st.adv[phy_mgmt_pkg::ADV_NEXT_PAGE] = 1'b0;

        // Power-up load wins over a coincident write on the three capability bits 9, 6 and 5
        if (i_init_load) begin
            next_st.cap_four_pair = i_init_four_pair_capability;
            next_st.cap_ten_full = i_init_ten_full_duplex;
            next_st.cap_ten_half = i_init_ten_half_duplex;
            next_st.phy_address = i_init_phy_address;
            next_st.adv[phy_mgmt_pkg::ADV_FOUR_PAIR] =
                i_init_four_pair_capability;
            next_st.adv[phy_mgmt_pkg::ADV_TEN_FULL] =
                i_init_ten_full_duplex;
            next_st.adv[phy_mgmt_pkg::ADV_TEN_HALF] =
                i_init_ten_half_duplex;
        end

        // ----------------------------------------
        // Link-side status
        // ----------------------------------------
        next_st.an_complete = i_autoneg_complete;
        next_st.lp_np_able = i_lp_next_page_able;
        next_st.lp_an_able = i_lp_autoneg_able;
        if (i_lp_word_valid) begin
            next_st.lp = i_lp_word;
        end
        // A fail during the read still leaves zero behind
        next_st.link_latched = rd_stat ? i_link_up
                                       : (st.link_latched & i_link_up);
        // Set wins over the read clear
        next_st.multi_fault = i_multi_link_good |
                              (st.multi_fault & ~rd_exp);
        next_st.page_rcvd = i_page_received |
                            (st.page_rcvd & ~rd_exp);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
            st.state <= ST_PREAMBLE;
            st.adv <= phy_mgmt_pkg::ADV_RESET;
        end else if (i_clk_en) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_mdio = st.mdio_out;
    assign o_mdio_oe = st.mdio_oe;
    assign o_advertisement = st.adv;

endmodule

// [verif/phy_mgmt_props.sv]
`timescale 1ns/1ps

module phy_mgmt_props (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_mdc,
    input wire logic i_init_load,
    input wire logic i_init_four_pair_capability,
    input wire logic i_init_ten_full_duplex,
    input wire logic i_init_ten_half_duplex,
    input wire logic o_mdio,
    input wire logic o_mdio_oe,
    input wire logic [15:0] o_advertisement
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------
    // Helper: management clock rises while driving
    // ----------------------------------------
    logic mdc_last;
    logic [5:0] drive_rises;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mdc_last <= 1'b0;
            drive_rises <= 6'h00;
        end else begin
            mdc_last <= i_mdc;
            if (!o_mdio_oe) begin
                drive_rises <= 6'h00;
            end else if (i_mdc && !mdc_last) begin
                drive_rises <= drive_rises + 6'h01;
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_adv_top;
        o_advertisement[15:14] == 2'h0;
    endproperty
    a_adv_top: assert property (p_adv_top)
        else $error("advertisement next page bit set");

    property p_adv_fixed;
        o_advertisement[4:0] == 5'h01 && o_advertisement[12:10] == 3'h0;
    endproperty
    a_adv_fixed: assert property (p_adv_fixed)
        else $error("advertisement fixed field wrong");

    property p_adv_reset;
        $rose(i_rst_n) |-> o_advertisement == 16'h0181;
    endproperty
    a_adv_reset: assert property (p_adv_reset)
        else $error("advertisement reset value wrong");

    property p_adv_load;
        i_init_load && i_clk_en |=>
            o_advertisement[9] == $past(i_init_four_pair_capability) &&
            o_advertisement[6] == $past(i_init_ten_full_duplex) &&
            o_advertisement[5] == $past(i_init_ten_half_duplex);
    endproperty
    a_adv_load: assert property (p_adv_load)
        else $error("advertisement defaults not loaded");

    property p_adv_hold_in_read;
        o_mdio_oe && !i_init_load |=> $stable(o_advertisement);
    endproperty
    a_adv_hold_in_read: assert property (p_adv_hold_in_read)
        else $error("advertisement changed during a read");

    property p_stands;
        (!i_mdc) [*8] |=> $stable(o_mdio) && $stable(o_mdio_oe);
    endproperty
    a_stands: assert property (p_stands)
        else $error("pin output moved without a clock rise");

    property p_turnaround_zero;
        $rose(o_mdio_oe) |-> !o_mdio;
    endproperty
    a_turnaround_zero: assert property (p_turnaround_zero)
        else $error("turnaround bit not driven low");

    property p_drive_length;
        $fell(o_mdio_oe) |-> drive_rises == 6'h11;
    endproperty
    a_drive_length: assert property (p_drive_length)
        else $error("read drive not seventeen clock rises long");

    c_read: cover property ($rose(o_mdio_oe));
    c_load: cover property (i_init_load);
    c_write: cover property ($changed(o_advertisement) && !$past(i_init_load));
endmodule

bind phy_mgmt_status_autoneg_regs phy_mgmt_props phy_mgmt_props_i (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_mdc(i_mdc),
    .i_init_load(i_init_load),
    .i_init_four_pair_capability(i_init_four_pair_capability),
    .i_init_ten_full_duplex(i_init_ten_full_duplex),
    .i_init_ten_half_duplex(i_init_ten_half_duplex),
    .o_mdio(o_mdio),
    .o_mdio_oe(o_mdio_oe),
    .o_advertisement(o_advertisement)
);

// [verif/mdio_station.sv]
`timescale 1ns/1ps

module mdio_station (
    input wire logic i_clk_sys,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_oe,
    output logic o_rd_valid,
    output logic [15:0] o_rd_data
);
    // Half period in system cycles; raise it for a slow master
    int half = 6;

    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_data = 16'h0000;
    end

    // Data moves in the low phase, sampled at the rise
    task automatic clk_bit(input logic drive, input logic b, output logic s);
        @(negedge i_clk_sys);
        o_mdio_oe = drive;
        o_mdio = drive ? b : ~o_mdio;
        repeat (half - 1) @(negedge i_clk_sys);
        o_mdc = 1'b1;
        s = i_mdio;
        repeat (half) @(negedge i_clk_sys);
        o_mdc = 1'b0;
    endtask

    task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] rg, input logic [15:0] wd,
                        input int pre);
        logic [13:0] hdr;
        logic [15:0] rd;
        logic s;
        hdr = {2'b01, op, phy, rg};
        for (int i = 0; i < pre; i++) clk_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
        if (op == phy_mgmt_pkg::OP_WRITE) begin
            clk_bit(1'b1, 1'b1, s);
            clk_bit(1'b1, 1'b0, s);
            for (int i = 15; i >= 0; i--) clk_bit(1'b1, wd[i], s);
        end else begin
            clk_bit(1'b0, 1'b0, s);
            clk_bit(1'b0, 1'b0, s);
            for (int i = 15; i >= 0; i--) begin
                clk_bit(1'b0, 1'b0, s);
                rd[i] = s;
            end
            @(negedge i_clk_sys);
            o_rd_data = rd;
            o_rd_valid = 1'b1;
            @(negedge i_clk_sys);
            o_rd_valid = 1'b0;
        end
        @(negedge i_clk_sys);
        o_mdio_oe = 1'b0;
        repeat (8) @(negedge i_clk_sys);
    endtask
endmodule

// [verif/tb_phy_mgmt_status_autoneg_regs.sv]
`timescale 1ns/1ps

module tb_phy_mgmt_status_autoneg_regs;
    localparam int PRE = 4;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic mdc, st_mdio, st_oe, rd_valid, dut_mdio, dut_oe, mdio_wire;
    logic [15:0] rd_data, adv_port, w, adv;
    logic load = 1'b0, hardwired = 1'b0, four = 1'b0, tf = 1'b0, th = 1'b0;
    logic link = 1'b0, an = 1'b0, lpv = 1'b0, pg = 1'b0, mlg = 1'b0;
    logic lpnp = 1'b0, lpan = 1'b0;
    logic [15:0] lpw = 16'h0000;
    logic [4:0] addr = 5'h13;
    logic [15:0] exp_q[$];
    string nm_q[$];
    int n_fail = 0, comparisons = 0, cycles = 0;
    logic [4:0] unused_regs[5] = '{5'h00, 5'h02, 5'h03, 5'h07, 5'h1f};

    always #50 i_clk_sys = ~i_clk_sys;
    // Pull-up on the shared data line
    assign mdio_wire = dut_oe ? dut_mdio : (st_oe ? st_mdio : 1'b1);

    mdio_station mdio_station_i (.i_clk_sys(i_clk_sys), .i_mdio(mdio_wire),
        .o_mdc(mdc), .o_mdio(st_mdio), .o_mdio_oe(st_oe),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data));

    phy_mgmt_status_autoneg_regs #(.PREAMBLE_LEN(PRE))
        phy_mgmt_status_autoneg_regs_i (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
        .i_mdc(mdc), .i_mdio(mdio_wire), .o_mdio(dut_mdio),
        .o_mdio_oe(dut_oe), .i_init_load(load),
        .i_init_hardwired(hardwired), .i_init_phy_address(addr),
        .i_init_four_pair_capability(four), .i_init_ten_full_duplex(tf),
        .i_init_ten_half_duplex(th), .i_link_up(link),
        .i_autoneg_complete(an), .i_lp_word_valid(lpv), .i_lp_word(lpw),
        .i_page_received(pg), .i_multi_link_good(mlg),
        .i_lp_next_page_able(lpnp), .i_lp_autoneg_able(lpan),
        .o_advertisement(adv_port));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        if (rd_valid === 1'b1) begin
            check(nm_q.pop_front(), exp_q.pop_front(), rd_data);
        end
    end

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            $display("ERROR timeout expected done seen hang");
            conclude();
        end
    end

    // ----------------------------------------
    // Frame helpers
    // ----------------------------------------
    function automatic logic [15:0] stat(input logic lk, input logic cp);
        return {four, 2'b11, tf, th, 5'h00, cp, 1'b0, 1'b1, lk, 1'b0, 1'b1};
    endfunction

    task automatic rd(input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        mdio_station_i.xfer(phy_mgmt_pkg::OP_READ, phy, rg, 16'h0000, PRE);
    endtask

    task automatic wr(input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] d);
        mdio_station_i.xfer(phy_mgmt_pkg::OP_WRITE, phy, rg, d, PRE);
    endtask

    task automatic pulse(ref logic sig);
        @(negedge i_clk_sys);
        sig = 1'b1;
        @(negedge i_clk_sys);
        sig = 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(19));
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        four = 1'($urandom);
        tf = 1'($urandom);
        th = 1'($urandom);
        addr = 5'h01 + 5'($urandom % 31);
        pulse(load);
        adv = 16'h0181 | {6'h00, four, 2'b00, tf, th, 5'h00};
        repeat (6) @(negedge i_clk_sys);
        check("adv_port", adv, adv_port);
        link = 1'b1;
        rd(addr, 5'h01, stat(1'b0, 1'b0), "status_first");
        rd(addr, 5'h01, stat(1'b1, 1'b0), "status_caps");
        link = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        link = 1'b1;
        an = 1'b1;
        rd(addr, 5'h01, stat(1'b0, 1'b1), "status_latched");
        rd(addr, 5'h01, stat(1'b1, 1'b1), "status_link");
        rd(addr, 5'h04, adv, "adv_reset");
        wr(addr, 5'h04, 16'hbfff);
        rd(addr, 5'h04, 16'h23e1, "adv_ones");
        wr(addr, 5'h04, 16'h0000);
        rd(addr, 5'h04, 16'h0001, "adv_zeros");
        w = 16'($urandom) & 16'hbfff;
        adv = (w & 16'h23e0) | 16'h0001;
        wr(addr, 5'h04, w);
        rd(addr, 5'h04, adv, "adv_random");
        check("adv_port", adv, adv_port);
        @(negedge i_clk_sys);
        lpw = 16'($urandom);
        pulse(lpv);
        rd(addr, 5'h05, lpw, "partner");
        lpnp = 1'b1;
        lpan = 1'b1;
        pulse(pg);
        pulse(mlg);
        rd(addr, 5'h06, 16'h001b, "expansion_set");
        rd(addr, 5'h06, 16'h0009, "expansion_clr");
        lpnp = 1'b0;
        lpan = 1'b0;
        rd(addr, 5'h06, 16'h0000, "expansion_idle");
        foreach (unused_regs[i]) begin
            rd(addr, unused_regs[i], 16'h0000, "unused");
        end
        rd(addr ^ 5'h01, 5'h04, 16'hffff, "other_address");
        wr(addr ^ 5'h01, 5'h04, 16'h0000);
        rd(addr, 5'h04, adv, "write_ignored");
        // Illegal op code: frame dropped, line stays on its pull-up
        exp_q.push_back(16'hffff);
        nm_q.push_back("bad_op");
        mdio_station_i.xfer(2'b11, addr, 5'h04, 16'h0000, PRE);
        hardwired = 1'b1;
        rd(5'h00, 5'h04, adv, "hardwired_zero");
        rd(addr, 5'h04, 16'hffff, "hardwired_other");
        mdio_station_i.half = 10;
        rd(5'h00, 5'h01, stat(1'b1, 1'b1), "slow_master");
        repeat (4) @(negedge i_clk_sys);
        check("pending", 16'h0000, 16'(exp_q.size()));
        conclude();
    end
endmodule
